//--- src/srs_pkg.sv
// Package with the constants, encodings and timing counts of the system reset controller.
// Contract
// - Reset forces all peripheral registers to initial values (code: cause flags and brown-out threshold survive all but power-on).
// - Reset never clears or rewrites static RAM.
// - Fetch starts at vector zero or boot start.
// - Port pins go high impedance immediately on reset.
// - Reset asserts asynchronously, no clock needed.
// - Readable cause register shows last reset source.
// - Low external reset pin holds device in reset.
// - Enabled watchdog expiry resets; own oscillator clocks it (code: core_clk counts its ticks, and the count freezes while ce is low).
// - Enabled brown-out resets; threshold is programmable.
// - Debug port reset request gives full reset.
package srs_pkg;

	// Number of reset sources and their bit positions in the cause flags.
	localparam int unsigned NUM_CAUSES = 6;
	localparam int unsigned CAUSE_POR  = 0;
	localparam int unsigned CAUSE_EXT  = 1;
	localparam int unsigned CAUSE_WDT  = 2;
	localparam int unsigned CAUSE_BOD  = 3;
	localparam int unsigned CAUSE_DBG  = 4;
	localparam int unsigned CAUSE_SW   = 5;

	// Cause flags left behind by a power-on reset.
	localparam logic [NUM_CAUSES-1:0] CAUSE_POR_ONLY = 6'h01;

	// Program address width and the application and boot reset vectors.
	localparam int unsigned           PC_W          = 17;
	localparam logic [PC_W-1:0]       VECTOR_APP    = 17'h00000;
	localparam logic [PC_W-1:0]       VECTOR_BOOT   = 17'h10000;

	// Brown-out threshold code width and its value after power-on.
	localparam int unsigned           BOD_LVL_W     = 3;
	localparam logic [BOD_LVL_W-1:0]  BOD_LVL_RST   = 3'h7;

	// Watchdog timeout: base ticks shifted left by the period select.
	localparam int unsigned           WDT_SEL_W     = 4;
	localparam int unsigned           WDT_CNT_W     = 20;
	localparam logic [WDT_CNT_W-1:0]  WDT_BASE      = 20'h00008;
	localparam logic [WDT_SEL_W-1:0]  WDT_SEL_MAX   = 4'hb;

	// Core clock period and the minimum time reset is held after all sources go quiet.
	localparam int unsigned           CLK_PERIOD_PS = 5000;
	localparam int unsigned           RST_HOLD_NS   = 100;
	localparam int unsigned           RST_HOLD_CYC  = (RST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned           HOLD_CNT_W    = 8;

	// Sequencer states.
	typedef enum logic [1:0] {
		SEQ_ASSERT,
		SEQ_HOLD,
		SEQ_RUN
	} srs_seq_type;

endpackage

//--- src/srs_wdt.sv
// Watchdog counter advanced by ticks of its own oscillator.
`timescale 1ns/1ps
`default_nettype none
module srs_wdt #(
	parameter int unsigned CNT_W = srs_pkg::WDT_CNT_W,
	parameter int unsigned SEL_W = srs_pkg::WDT_SEL_W
) (
	input  wire logic             core_clk,   // Core clock.
	input  wire logic             ce,         // Clock enable, freezes state when low.
	input  wire logic             rst,        // Synchronous clear, high during any reset.
	input  wire logic             wdt_en,     // Watchdog reset enable.
	input  wire logic [SEL_W-1:0] period_sel, // Timeout select.
	input  wire logic             osc_tick,   // One pulse per watchdog oscillator period.
	input  wire logic             kick,       // Software restart of the count.
	output logic                  expired_q   // Sticky expiry, held until reset.
);

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic             expired_d;
	logic [CNT_W-1:0] limit;
	logic [SEL_W-1:0] sel_clip;

	// Timeout grows by powers of two; larger selects are clipped so the limit never overflows.
	always_comb begin
		sel_clip = (period_sel > srs_pkg::WDT_SEL_MAX) ? srs_pkg::WDT_SEL_MAX : period_sel;
		limit    = srs_pkg::WDT_BASE << sel_clip;
	end

	// Count only the watchdog oscillator ticks, so while ce is high the timeout does not depend on the core clock.
	always_comb begin
		cnt_d     = cnt_q;
		expired_d = expired_q;
		if (!wdt_en || kick) begin
			cnt_d = '0;
		end else if (osc_tick && !expired_q) begin
			if (cnt_q >= limit - 1'b1) begin
				expired_d = 1'b1;
			end else begin
				cnt_d = cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cnt_q     <= '0;
			expired_q <= 1'b0;
		end else if (ce) begin
			cnt_q     <= cnt_d;
			expired_q <= expired_d;
		end
	end

endmodule
`default_nettype wire

//--- src/srs_cause.sv
// Sticky reset cause flags, one per source, with write-one clear.
`timescale 1ns/1ps
`default_nettype none
module srs_cause #(
	parameter int unsigned N = srs_pkg::NUM_CAUSES
) (
	input  wire logic         core_clk, // Core clock.
	input  wire logic         ce,       // Clock enable.
	input  wire logic         por,      // Power-on reset, clears all flags but its own.
	input  wire logic [N-1:0] set,      // Source currently causing a reset.
	input  wire logic [N-1:0] clr,      // Write-one-to-clear strobes.
	output logic      [N-1:0] flags_q   // Cause flags.
);

	logic [N-1:0] flags_d;

	// A set in the same cycle as its clear wins, so no cause is lost.
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_flag
			always_comb begin
				flags_d[i] = set[i] | (flags_q[i] & ~clr[i]);
			end
		end
	endgenerate

	// These flags are deliberately outside the system reset so software can read them afterwards.
	always_ff @(posedge core_clk) begin
		if (por) begin
			flags_q <= srs_pkg::CAUSE_POR_ONLY;
		end else if (ce) begin
			flags_q <= flags_d;
		end
	end

endmodule
`default_nettype wire

//--- src/srs_reset_ctrl.sv
// System reset controller: gathers reset sources and sequences the device reset.
`timescale 1ns/1ps
`default_nettype none
module srs_reset_ctrl #(
	parameter int unsigned           HOLD_CYC    = srs_pkg::RST_HOLD_CYC,
	parameter logic [srs_pkg::PC_W-1:0] BOOT_VECTOR = srs_pkg::VECTOR_BOOT
) (
	input  wire logic                          core_clk,       // Core clock, 200 MHz.
	input  wire logic                          srst,           // Power-on reset, active high.
	input  wire logic                          ce,             // Clock enable.
	input  wire logic                          ext_rst_n,      // External reset pin, active low.
	input  wire logic                          wdt_en,         // Watchdog reset enable.
	input  wire logic [srs_pkg::WDT_SEL_W-1:0] wdt_period_sel, // Watchdog timeout select.
	input  wire logic                          wdt_osc_tick,   // Watchdog oscillator tick.
	input  wire logic                          wdt_kick,       // Watchdog restart.
	input  wire logic                          bod_en,         // Brown-out detector enable.
	input  wire logic                          bod_low,        // Supply below threshold.
	input  wire logic [srs_pkg::BOD_LVL_W-1:0] bod_level,      // Requested brown-out threshold.
	input  wire logic                          bod_level_wr,   // Load the threshold.
	input  wire logic                          debug_port_reset_request, // Reset from debug port.
	input  wire logic                          sw_reset_req,   // Software reset request pulse.
	input  wire logic                          boot_vec_sel,   // Start from boot section.
	input  wire logic [srs_pkg::NUM_CAUSES-1:0] cause_clr,     // Write-one-to-clear cause flags.
	output logic                               sys_rst_q,      // Reset to core and peripherals.
	output logic                               port_hiz_q,     // Tri-state all general ports.
	output logic                               sram_guard_q,   // Blocks SRAM writes during reset.
	output logic [srs_pkg::PC_W-1:0]           reset_vector_q, // First fetch address.
	output logic [srs_pkg::BOD_LVL_W-1:0]      bod_level_q,    // Threshold to the detector.
	output logic [srs_pkg::NUM_CAUSES-1:0]     cause_q         // Reset cause flags.
);

	srs_pkg::srs_seq_type                state_q;
	srs_pkg::srs_seq_type                state_d;
	logic [srs_pkg::HOLD_CNT_W-1:0]      hold_q;
	logic [srs_pkg::HOLD_CNT_W-1:0]      hold_d;
	logic                                rel_meta_q;
	logic                                rel_q;
	logic                                sys_rst_d;
	logic                                port_hiz_d;
	logic                                sram_guard_d;
	logic [srs_pkg::PC_W-1:0]            reset_vector_d;
	logic [srs_pkg::BOD_LVL_W-1:0]       bod_level_d;
	logic                                sw_pend_q;
	logic                                sw_pend_d;
	logic                                dbg_pend_q;
	logic                                dbg_pend_d;
	logic                                wdt_expired;
	logic                                wdt_rst;
	logic                                ext_hit;
	logic                                wdt_hit;
	logic                                bod_hit;
	logic                                dbg_hit;
	logic                                sw_hit;
	logic                                async_hit;
	logic [srs_pkg::NUM_CAUSES-1:0]      cause_set;
	logic                                hold_done;

	// The watchdog is itself cleared by every reset, so its expiry drops once reset takes hold.
	assign wdt_rst = srst | sys_rst_q;

	srs_wdt #(
		.CNT_W (srs_pkg::WDT_CNT_W),
		.SEL_W (srs_pkg::WDT_SEL_W)
	) u_wdt (
		.core_clk   (core_clk),
		.ce         (ce),
		.rst        (wdt_rst),
		.wdt_en     (wdt_en),
		.period_sel (wdt_period_sel),
		.osc_tick   (wdt_osc_tick),
		.kick       (wdt_kick),
		.expired_q  (wdt_expired)
	);

	// Source qualification; each source is gated by its own enable where it has one.
	always_comb begin
		ext_hit = ~ext_rst_n;
		wdt_hit = wdt_expired & wdt_en;
		bod_hit = bod_low & bod_en;
		dbg_hit = debug_port_reset_request | dbg_pend_q;
		sw_hit  = sw_reset_req | sw_pend_q;
	end

	// Any active source. This is combinational by intent: it sets reset without a clock edge,
	// at the cost of needing glitch-free source signals from the analog detectors.
	assign async_hit = srst | ext_hit | wdt_hit | bod_hit | dbg_hit | sw_hit;

	// Requests that arrive as pulses are kept pending until reset is actually in effect,
	// so a short request cannot be missed while the clock is gated off.
	always_comb begin
		sw_pend_d  = sw_reset_req | (sw_pend_q & ~sys_rst_q);
		dbg_pend_d = debug_port_reset_request | (dbg_pend_q & ~sys_rst_q);
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			sw_pend_q  <= 1'b0;
			dbg_pend_q <= 1'b0;
		end else if (ce) begin
			sw_pend_q  <= sw_pend_d;
			dbg_pend_q <= dbg_pend_d;
		end
	end

	// Release synchroniser: set at once by any source, cleared two edges after sources end.
	// The first stage is read only by the second.
	always_ff @(posedge core_clk or posedge async_hit) begin
		if (async_hit) begin
			rel_meta_q <= 1'b1;
			rel_q      <= 1'b1;
		end else if (ce) begin
			rel_meta_q <= 1'b0;
			rel_q      <= rel_meta_q;
		end
	end

	assign hold_done = (hold_q >= HOLD_CYC[srs_pkg::HOLD_CNT_W-1:0] - 1'b1);

	// Sequencer: stay asserted while any source is active, then hold for a minimum time.
	always_comb begin
		state_d = state_q;
		hold_d  = hold_q;
		case (state_q)
			srs_pkg::SEQ_ASSERT: begin
				hold_d = '0;
				if (!rel_q) begin
					state_d = srs_pkg::SEQ_HOLD;
				end
			end
			srs_pkg::SEQ_HOLD: begin
				if (rel_q) begin
					state_d = srs_pkg::SEQ_ASSERT;
					hold_d  = '0;
				end else if (hold_done) begin
					state_d = srs_pkg::SEQ_RUN;
				end else begin
					hold_d = hold_q + 1'b1;
				end
			end
			srs_pkg::SEQ_RUN: begin
				if (rel_q) begin
					state_d = srs_pkg::SEQ_ASSERT;
				end
			end
			default: begin
				state_d = srs_pkg::SEQ_ASSERT;
				hold_d  = '0;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_q <= srs_pkg::SEQ_ASSERT;
			hold_q  <= '0;
		end else if (ce) begin
			state_q <= state_d;
			hold_q  <= hold_d;
		end
	end

	// Reset outputs stay high until the sequencer enters run; the fan-out of sys_rst_q drives
	// every peripheral register outside this module back to its initial value; bod_level_q and cause_q keep theirs.
	always_comb begin
		sys_rst_d    = (state_d != srs_pkg::SEQ_RUN);
		port_hiz_d   = (state_d != srs_pkg::SEQ_RUN);
		sram_guard_d = (state_d != srs_pkg::SEQ_RUN);
	end

	// Asynchronous set makes the ports float the moment a source goes active, with no clock.
	always_ff @(posedge core_clk or posedge async_hit) begin
		if (async_hit) begin
			sys_rst_q    <= 1'b1;
			port_hiz_q   <= 1'b1;
			sram_guard_q <= 1'b1;
		end else if (ce) begin
			sys_rst_q    <= sys_rst_d;
			port_hiz_q   <= port_hiz_d;
			sram_guard_q <= sram_guard_d;
		end
	end

	// The vector is chosen at the end of the hold, so a change of the boot select
	// takes effect at the next reset and never under a running program.
	always_comb begin
		reset_vector_d = reset_vector_q;
		if (state_q == srs_pkg::SEQ_HOLD && !rel_q && hold_done) begin
			reset_vector_d = boot_vec_sel ? BOOT_VECTOR : srs_pkg::VECTOR_APP;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			reset_vector_q <= srs_pkg::VECTOR_APP;
		end else if (ce) begin
			reset_vector_q <= reset_vector_d;
		end
	end

	// Brown-out threshold survives ordinary resets; only power-on restores its default,
	// otherwise a brown-out reset would forget the level that caused it.
	always_comb begin
		bod_level_d = bod_level_wr ? bod_level : bod_level_q;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			bod_level_q <= srs_pkg::BOD_LVL_RST;
		end else if (ce) begin
			bod_level_q <= bod_level_d;
		end
	end

	// Record every source that is active while it drives the device into reset.
	always_comb begin
		cause_set                     = '0;
		cause_set[srs_pkg::CAUSE_POR] = srst;
		cause_set[srs_pkg::CAUSE_EXT] = ext_hit;
		cause_set[srs_pkg::CAUSE_WDT] = wdt_hit;
		cause_set[srs_pkg::CAUSE_BOD] = bod_hit;
		cause_set[srs_pkg::CAUSE_DBG] = dbg_hit;
		cause_set[srs_pkg::CAUSE_SW]  = sw_hit;
	end

	srs_cause #(
		.N (srs_pkg::NUM_CAUSES)
	) u_cause (
		.core_clk (core_clk),
		.ce       (ce),
		.por      (srst),
		.set      (cause_set),
		.clr      (cause_clr),
		.flags_q  (cause_q)
	);

endmodule
`default_nettype wire

//--- tb/srs_osc_model.sv
// Stand-in for the watchdog's own oscillator, ticking apart from the core.
`timescale 1ns/1ps
`default_nettype none
module srs_osc_model #(
	parameter int unsigned DIV = 3 // Core cycles per tick.
) (
	input  wire logic core_clk, // Core clock, only shapes the tick.
	output var logic  tick      // One-cycle tick.
);
	int unsigned n = 0;
	initial tick = 1'b0;
	// Free-running divider; the reset never stops the watchdog's oscillator.
	always @(posedge core_clk) begin
		n <= (n + 1) % DIV;
		tick <= #1 (n == DIV - 1);
	end
endmodule
`default_nettype wire

//--- tb/srs_reset_ctrl_props.sv
// Concurrent checks on the ports of the system reset controller.
`timescale 1ns/1ps
`default_nettype none
module srs_reset_ctrl_props (
	input wire logic       core_clk,                 // Clock.
	input wire logic       srst,                     // Power-on reset.
	input wire logic       ce,                       // Clock enable.
	input wire logic       ext_rst_n,                // Reset pin.
	input wire logic       bod_en,                   // Brown-out enable.
	input wire logic       bod_low,                  // Low supply.
	input wire logic       debug_port_reset_request, // Debug reset.
	input wire logic       sw_reset_req,             // Software reset.
	input wire logic [5:0] cause_clr,                // Flag clears.
	input wire logic       sys_rst_q,                // Core reset.
	input wire logic       port_hiz_q,               // Port tri-state.
	input wire logic       sram_guard_q,             // Memory guard.
	input wire logic [5:0] cause_q                   // Cause flags.
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	// The pin resets at once and leaves its flag one edge later.
	AST_EXT: assert property (!ext_rst_n && ce |-> sys_rst_q ##1 cause_q[1])
		else $error("pin reset not seen");
	AST_HIZ: assert property (port_hiz_q == sys_rst_q)
		else $error("ports not tri-stated with reset");
	AST_GUARD: assert property (sram_guard_q == sys_rst_q)
		else $error("memory guard differs from reset");
	AST_SW: assert property (sw_reset_req && ce |-> sys_rst_q ##1 cause_q[5])
		else $error("software reset not recorded");
	AST_DBG: assert property (debug_port_reset_request |-> sys_rst_q)
		else $error("debug reset not taken");
	AST_BOD: assert property (bod_en && bod_low |-> sys_rst_q)
		else $error("brown-out reset not taken");
	AST_CLR: assert property (ce && cause_clr[1] && ext_rst_n |=> !cause_q[1])
		else $error("pin flag not cleared");
	// Power-on has its own disable, since it is the reset itself.
	AST_POR: assert property (disable iff (1'b0) srst |=> cause_q[0])
		else $error("power-on flag missing");
	cover property ($fell(sys_rst_q));
	cover property (!ext_rst_n);
	cover property (sw_reset_req);
endmodule
bind srs_reset_ctrl srs_reset_ctrl_props i_srs_reset_ctrl_props (.core_clk(core_clk), .srst(srst), .ce(ce),
	.ext_rst_n(ext_rst_n), .bod_en(bod_en), .bod_low(bod_low), .sw_reset_req(sw_reset_req),
	.debug_port_reset_request(debug_port_reset_request), .cause_clr(cause_clr), .sys_rst_q(sys_rst_q),
	.port_hiz_q(port_hiz_q), .sram_guard_q(sram_guard_q), .cause_q(cause_q));
`default_nettype wire

//--- tb/tb_srs_reset_ctrl.sv
// Self-checking testbench for the system reset controller.
`timescale 1ns/1ps
`default_nettype none
module tb_srs_reset_ctrl;
	localparam logic [16:0] BOOT = 17'h10000;
	logic        core_clk = 0, srst = 1, ce = 1, ext_n = 1, wdt_en = 0, kick = 0;
	logic        bod_en = 0, bod_low = 0, lvl_wr = 0, dbg = 0, sw = 0, boot = 0, tick;
	logic [3:0]  wsel = 4'h0;
	logic [2:0]  lvl = 3'h0, lvl_q;
	logic [5:0]  clr = 6'h00, cause_q;
	logic        sys_rst_q, port_hiz_q, sram_guard_q;
	logic [16:0] vec;
	int          err_total = 0, compares = 0;
	// A short hold keeps each reset to a handful of cycles.
	srs_reset_ctrl #(.HOLD_CYC(2), .BOOT_VECTOR(BOOT)) i_srs_reset_ctrl (.core_clk(core_clk), .srst(srst),
		.ce(ce), .ext_rst_n(ext_n), .wdt_en(wdt_en), .wdt_period_sel(wsel), .wdt_osc_tick(tick),
		.wdt_kick(kick), .bod_en(bod_en), .bod_low(bod_low), .bod_level(lvl), .bod_level_wr(lvl_wr),
		.debug_port_reset_request(dbg), .sw_reset_req(sw), .boot_vec_sel(boot), .cause_clr(clr),
		.sys_rst_q(sys_rst_q), .port_hiz_q(port_hiz_q), .sram_guard_q(sram_guard_q),
		.reset_vector_q(vec), .bod_level_q(lvl_q), .cause_q(cause_q));
	srs_osc_model i_srs_osc_model (.core_clk(core_clk), .tick(tick));
	// Clock at 200 MHz.
	initial begin
		forever #2.5 core_clk = ~core_clk;
	end
	task automatic stop_test;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Inputs always move one nanosecond after the rising edge.
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// Bounded wait for the end of the reset, which must also free the ports.
	task automatic wait_rel;
		int i;
		for (i = 0; i < 60 && sys_rst_q !== 1'b0; i++) cyc(1);
		chk("release", 0, sys_rst_q);
		chk("ports", 0, port_hiz_q);
		chk("guard", 0, sram_guard_q);
	endtask
	task automatic wipe;
		clr = 6'h3f;
		cyc(1);
		clr = 6'h00;
		chk("wipe", 0, cause_q);
	endtask
	task automatic t_por;
		chk("por hiz", 1, port_hiz_q);
		chk("por guard", 1, sram_guard_q);
		srst = 0;
		wait_rel();
		chk("por cause", 6'h01, cause_q);
		chk("por level", 3'h7, lvl_q);
		chk("vec app", 0, vec);
	endtask
	task automatic t_ext;
		ext_n = 0;
		#1 chk("ext async", 1, sys_rst_q);
		cyc(8);
		chk("ext held", 1, sys_rst_q);
		ext_n = 1;
		wait_rel();
		chk("ext cause", 6'h03, cause_q);
	endtask
	// Expiry is refused while disabled, then must come within a bounded span.
	task automatic t_wdt;
		int i;
		wipe();
		cyc(60);
		chk("wdt off", 0, sys_rst_q);
		// Regular restarts inside the doubled timeout must keep the device running.
		wsel = 4'h1;
		wdt_en = 1;
		repeat (6) begin
			kick = 1;
			cyc(1);
			kick = 0;
			cyc(9);
		end
		chk("wdt kicked", 0, sys_rst_q);
		for (i = 0; i < 80 && sys_rst_q !== 1'b1; i++) cyc(1);
		chk("wdt fire", 1, sys_rst_q);
		// The enable must still stand at the next edge, where the cause flag is taken.
		cyc(1);
		wdt_en = 0;
		wsel = 4'h0;
		wait_rel();
		chk("wdt cause", 6'h04, cause_q);
	endtask
	task automatic t_bod;
		wipe();
		bod_low = 1;
		lvl = 3'h2;
		lvl_wr = 1;
		cyc(1);
		lvl_wr = 0;
		chk("bod off", 0, sys_rst_q);
		chk("bod level", 3'h2, lvl_q);
		bod_en = 1;
		#1 chk("bod on", 1, sys_rst_q);
		cyc(2);
		bod_low = 0;
		wait_rel();
		chk("bod cause", 6'h08, cause_q);
		chk("bod kept", 3'h2, lvl_q);
	endtask
	// A stopped clock must not let the reset go.
	task automatic t_dbg;
		wipe();
		boot = 1;
		dbg = 1;
		cyc(1);
		dbg = 0;
		ce = 0;
		cyc(30);
		chk("ce freeze", 1, sys_rst_q);
		ce = 1;
		wait_rel();
		chk("dbg cause", 6'h10, cause_q);
		chk("vec boot", BOOT, vec);
		boot = 0;
	endtask
	task automatic t_sw;
		wipe();
		sw = 1;
		cyc(1);
		sw = 0;
		chk("sw hiz", 1, port_hiz_q);
		wait_rel();
		chk("sw cause", 6'h20, cause_q);
		chk("vec back", 0, vec);
	endtask
	initial begin
		cyc(10);
		t_por();
		t_ext();
		t_wdt();
		t_bod();
		t_dbg();
		t_sw();
		stop_test();
	end
	// The tests need well under a thousand cycles; this is ten times that.
	initial begin
		#50us;
		err_total++;
		stop_test();
	end
endmodule
`default_nettype wire
